// *** inc/spsms_pkg.sv ***
// constants, field positions and state encoding for the socket power smbus slave
// assumes the includer imports the whole package
package spsms_pkg;

  // ----------------------------------------------------------------
  // addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] IPTR_ADDR = 7'h0c;
  localparam logic [4:0] CHAN_ADDR_BASE = 5'h14;
  localparam logic IPTR_LSB = 1'b0;

  // ----------------------------------------------------------------
  // command byte fields
  // ----------------------------------------------------------------
  localparam int B_LATCH_TARGET = 7;
  localparam int B_MAIN_ON = 6;
  localparam int B_LEVEL_SEL = 5;
  localparam int B_MAIN_FLOAT = 4;
  localparam int B_PROG_ON = 3;
  localparam int B_PROG_HIGH = 2;
  localparam int B_PROG_FLOAT = 1;
  localparam int B_IRQ_MASK = 0;

  // ----------------------------------------------------------------
  // status byte fields and reset values
  // ----------------------------------------------------------------
  localparam int S_FAULT_TOP = 7;
  localparam int S_VARIANT = 2;
  localparam logic VARIANT_DUAL = 1'b0;
  localparam logic [1:0] STATUS_RSVD = 2'h0;
  localparam logic [6:0] CMD_RESET = 7'h00;
  localparam logic [4:0] FAULT_RESET = 5'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int SYNC_W = 9;

  // ----------------------------------------------------------------
  // link states, gray along address, ack, data, ack
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_WDATA = 3'h2,
    ST_WDATA_ACK = 3'h6,
    ST_RDATA = 3'h7,
    ST_RDATA_ACK = 3'h5,
    ST_IGNORE = 3'h4
  } spsms_state_type;

endpackage

// *** hdl/spsms_sync3.sv ***
// three-stage input synchroniser with agreement filter
// assumes inputs are asynchronous to clk; output moves when stages two and three agree
`timescale 1ns/1ps
module spsms_sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] filt
);

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;

  always_comb begin
    filt_d = filt_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        filt_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  assign filt = filt_q;

endmodule

// *** hdl/spsms_slave.sv ***
// smbus slave control for a dual-socket power switch: addressing, command latches,
// fault latches and open-drain fault interrupt
// assumes the bus clock is slow against core_clk (at least eight core clocks per bus clock)
`timescale 1ns/1ps
// Overview of operation
// - decode interrupt-pointer address and two channel addresses picked by address select
// - writes to the interrupt-pointer address are not acknowledged nor executed
// - read of channel-A address returns one byte with faults of both channels
// - after start, seven address bits then direction bit, one means read
// - acknowledge on address match; otherwise stay off bus until next start
// - write takes exactly one byte; partial byte cut by stop or start is dropped
// - write acknowledges address byte and then the command byte
// - on stop, top bit one loads normal latch, zero loads suspend latch
// - suspend pin high applies normal latch, low applies suspend latch
// - bit 6 main on, bit 5 level, bit 4 float overriding bit 6
// - bit 3 prog on, bit 2 prog high, bit 1 float overriding bit 3
// - channel-A bit 0 masks fault interrupts; channel-B bit 0 unused
// - reset clears commands and faults: outputs grounded, interrupt unmasked
// - status bits 7 to 3 hold latched severe and overcurrent flags
// - status bit 2 is variant constant, bits 1 and 0 read zero
// - on read the slave shifts data with host clock; host ends with no-ack
// - repeated start after a write is accepted and turns the transfer to read
// - any unmasked fault pulls interrupt low at once and keeps it latched
// - interrupt-pointer read releases interrupt, sends own address, latches keep first data
// - status read clears fault latches; a present fault relatches and reasserts
// - bit arbitration on pointer reply; loser stops driving and keeps interrupt
// - slave only; the interrupt line is the only unsolicited signal
module spsms_slave
  import spsms_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // smbus pins
  input wire logic smb_clk_pin,
  input wire logic smb_data_in,
  output logic smb_data_out,
  output logic smb_data_oe_n,
  // straps and mode pins
  input wire logic addr_sel_pin,
  input wire logic suspend_select_pin,
  // fault detectors from the analog side
  input wire logic severe_fault_det,
  input wire logic sock_a_main_oc_det,
  input wire logic sock_a_prog_oc_det,
  input wire logic sock_b_main_oc_det,
  input wire logic sock_b_prog_oc_det,
  // fault interrupt, open drain
  output logic irq_out,
  output logic irq_oe_n,
  // socket a switch controls
  output logic sock_a_main_on,
  output logic sock_a_level_sel,
  output logic sock_a_main_float,
  output logic sock_a_prog_on,
  output logic sock_a_prog_high,
  output logic sock_a_prog_float,
  // socket b switch controls
  output logic sock_b_main_on,
  output logic sock_b_level_sel,
  output logic sock_b_main_float,
  output logic sock_b_prog_on,
  output logic sock_b_prog_high,
  output logic sock_b_prog_float
);

  // ----------------------------------------------------------------
  // input synchronisation and bus conditions
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_raw, sync_out;
  logic scl, sda, addr_sel, suspend_pin;
  logic [4:0] fault_now;
  logic scl_prev_q, sda_prev_q;
  logic start_ev, stop_ev, scl_rise, scl_fall;

  assign sync_raw = {severe_fault_det, sock_a_main_oc_det, sock_a_prog_oc_det, sock_b_main_oc_det,
                     sock_b_prog_oc_det, suspend_select_pin, addr_sel_pin, smb_data_in, smb_clk_pin};

  spsms_sync3 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .raw(sync_raw),
    .filt(sync_out)
  );

  assign scl = sync_out[0];
  assign sda = sync_out[1];
  assign addr_sel = sync_out[2];
  assign suspend_pin = sync_out[3];
  assign fault_now = sync_out[8:4];

  assign start_ev = scl && scl_prev_q && sda_prev_q && !sda;
  assign stop_ev = scl && scl_prev_q && !sda_prev_q && sda;
  assign scl_rise = scl && !scl_prev_q;
  assign scl_fall = !scl && scl_prev_q;

  // ----------------------------------------------------------------
  // link state machine
  // ----------------------------------------------------------------
  spsms_state_type state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic rd_q, rd_d;
  logic ip_q, ip_d;
  logic chan_q, chan_d;
  logic ack_q, ack_d;
  logic pend_q, pend_d;
  logic sda_oe_n_q, sda_oe_n_d;
  logic commit, ld_status, ip_done, load;
  logic irq_pend_q;
  logic [7:0] status_byte;
  logic [6:0] chan_a_addr;
  logic [4:0] fault_lat_q;

  assign chan_a_addr = {CHAN_ADDR_BASE, addr_sel, 1'b0};
  assign status_byte = {fault_lat_q, VARIANT_DUAL, STATUS_RSVD};

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    wbyte_d = wbyte_q;
    rd_d = rd_q;
    ip_d = ip_q;
    chan_d = chan_q;
    ack_d = ack_q;
    pend_d = pend_q;
    sda_oe_n_d = sda_oe_n_q;
    commit = 1'b0;
    ip_done = 1'b0;
    load = 1'b0;
    if (start_ev) begin
      // a repeated start also executes a finished write
      commit = pend_q;
      pend_d = 1'b0;
      state_d = ST_ADDR;
      cnt_d = '0;
      sda_oe_n_d = 1'b1;
    end else if (stop_ev) begin
      commit = pend_q;
      pend_d = 1'b0;
      state_d = ST_IDLE;
      sda_oe_n_d = 1'b1;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
            cnt_d = '0;
            rd_d = sh_q[0];
            chan_d = sh_q[1];
            if (sh_q[7:1] == IPTR_ADDR && sh_q[0] && irq_pend_q) begin
              // only an interrupting device answers the pointer
              ip_d = 1'b1;
              state_d = ST_ADDR_ACK;
              sda_oe_n_d = 1'b0;
            end else if (sh_q[7:3] == CHAN_ADDR_BASE && sh_q[2] == addr_sel) begin
              ip_d = 1'b0;
              state_d = ST_ADDR_ACK;
              sda_oe_n_d = 1'b0;
            end else begin
              state_d = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_n_d = 1'b1;
            if (rd_q) begin
              load = 1'b1;
            end else begin
              state_d = ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
            wbyte_d = sh_q;
            state_d = ST_WDATA_ACK;
            sda_oe_n_d = 1'b0;
          end
        end
        ST_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe_n_d = 1'b1;
            pend_d = 1'b1;
            // exactly one byte per write, the rest is left unanswered
            state_d = ST_IGNORE;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
            if (tx_q[7] && !sda) begin
              // lost arbitration: drop off, interrupt stays pending
              state_d = ST_IGNORE;
              sda_oe_n_d = 1'b1;
            end
          end else if (scl_fall) begin
            if (cnt_q == BITS_PER_BYTE) begin
              sda_oe_n_d = 1'b1;
              ip_done = ip_q;
              state_d = ST_RDATA_ACK;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
              sda_oe_n_d = tx_q[6];
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            ack_d = !sda;
          end else if (scl_fall) begin
            if (ack_q) begin
              load = 1'b1;
            end else begin
              state_d = ST_IGNORE;
            end
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
    ld_status = load && !ip_q;
    if (load) begin
      // first bit goes out on the falling edge that ends the ack slot
      tx_d = ip_q ? {chan_a_addr, IPTR_LSB} : status_byte;
      sda_oe_n_d = tx_d[7];
      cnt_d = '0;
      state_d = ST_RDATA;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_q <= 1'b0;
      sda_prev_q <= 1'b0;
      state_q <= ST_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      tx_q <= '0;
      wbyte_q <= '0;
      rd_q <= 1'b0;
      ip_q <= 1'b0;
      chan_q <= 1'b0;
      ack_q <= 1'b0;
      pend_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else begin
      scl_prev_q <= scl;
      sda_prev_q <= sda;
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      wbyte_q <= wbyte_d;
      rd_q <= rd_d;
      ip_q <= ip_d;
      chan_q <= chan_d;
      ack_q <= ack_d;
      pend_q <= pend_d;
      sda_oe_n_q <= sda_oe_n_d;
    end
  end

  // ----------------------------------------------------------------
  // command latches, fault latches, interrupt and switch outputs
  // ----------------------------------------------------------------
  logic [6:0] norm_a_q, norm_a_d, norm_b_q, norm_b_d;
  logic [6:0] susp_a_q, susp_a_d, susp_b_q, susp_b_d;
  logic [6:0] apply_a, apply_b;
  logic [4:0] fault_lat_d;
  logic irq_pend_d, irq_oe_n_q, irq_oe_n_d;
  logic [11:0] out_q, out_d;

  assign apply_a = suspend_pin ? norm_a_q : susp_a_q;
  assign apply_b = suspend_pin ? norm_b_q : susp_b_q;

  always_comb begin
    norm_a_d = norm_a_q;
    norm_b_d = norm_b_q;
    susp_a_d = susp_a_q;
    susp_b_d = susp_b_q;
    if (commit) begin
      if (wbyte_q[B_LATCH_TARGET]) begin
        if (chan_q) begin
          norm_b_d = wbyte_q[6:0];
        end else begin
          norm_a_d = wbyte_q[6:0];
        end
      end else begin
        if (chan_q) begin
          susp_b_d = wbyte_q[6:0];
        end else begin
          susp_a_d = wbyte_q[6:0];
        end
      end
    end
    // latches hold the first capture until a status read; a new fault wins over the clear
    fault_lat_d = ld_status ? FAULT_RESET : fault_lat_q;
    if (fault_lat_d == FAULT_RESET) begin
      fault_lat_d = fault_now;
    end
    // set wins over clear so a lasting fault reasserts at once
    irq_pend_d = (irq_pend_q && !(ip_done || ld_status)) || (|fault_now);
    // mask from channel a only; channel b bit 0 is ignored
    irq_oe_n_d = !(irq_pend_d && !apply_a[B_IRQ_MASK]);
    // float overrides the on bit
    out_d = {apply_b[B_MAIN_ON] && !apply_b[B_MAIN_FLOAT], apply_b[B_LEVEL_SEL], apply_b[B_MAIN_FLOAT],
             apply_b[B_PROG_ON] && !apply_b[B_PROG_FLOAT], apply_b[B_PROG_HIGH], apply_b[B_PROG_FLOAT],
             apply_a[B_MAIN_ON] && !apply_a[B_MAIN_FLOAT], apply_a[B_LEVEL_SEL], apply_a[B_MAIN_FLOAT],
             apply_a[B_PROG_ON] && !apply_a[B_PROG_FLOAT], apply_a[B_PROG_HIGH], apply_a[B_PROG_FLOAT]};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      norm_a_q <= CMD_RESET;
      norm_b_q <= CMD_RESET;
      susp_a_q <= CMD_RESET;
      susp_b_q <= CMD_RESET;
      fault_lat_q <= FAULT_RESET;
      irq_pend_q <= 1'b0;
      irq_oe_n_q <= 1'b1;
      out_q <= '0;
    end else begin
      norm_a_q <= norm_a_d;
      norm_b_q <= norm_b_d;
      susp_a_q <= susp_a_d;
      susp_b_q <= susp_b_d;
      fault_lat_q <= fault_lat_d;
      irq_pend_q <= irq_pend_d;
      irq_oe_n_q <= irq_oe_n_d;
      out_q <= out_d;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers: both lines only ever pull low
  // ----------------------------------------------------------------
  logic low_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= 1'b0;
    end else begin
      low_q <= 1'b0;
    end
  end

  assign smb_data_out = low_q;
  assign smb_data_oe_n = sda_oe_n_q;
  assign irq_out = low_q;
  assign irq_oe_n = irq_oe_n_q;
  assign sock_a_prog_float = out_q[0];
  assign sock_a_prog_high = out_q[1];
  assign sock_a_prog_on = out_q[2];
  assign sock_a_main_float = out_q[3];
  assign sock_a_level_sel = out_q[4];
  assign sock_a_main_on = out_q[5];
  assign sock_b_prog_float = out_q[6];
  assign sock_b_prog_high = out_q[7];
  assign sock_b_prog_on = out_q[8];
  assign sock_b_main_float = out_q[9];
  assign sock_b_level_sel = out_q[10];
  assign sock_b_main_on = out_q[11];

endmodule

// *** tb/spsms_asserts.sv ***
// checker for the socket power smbus slave, bound to its ports
// assumes bus traffic slow against core_clk and no unmask while a fault is pending
`timescale 1ns/1ps
module spsms_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bus pins
  input wire logic smb_clk_pin,
  input wire logic smb_data_out,
  input wire logic smb_data_oe_n,
  // faults and interrupt
  input wire logic severe_fault_det,
  input wire logic sock_a_main_oc_det,
  input wire logic sock_a_prog_oc_det,
  input wire logic sock_b_main_oc_det,
  input wire logic sock_b_prog_oc_det,
  input wire logic irq_out,
  input wire logic irq_oe_n,
  // switch controls
  input wire logic sock_a_main_on,
  input wire logic sock_a_main_float,
  input wire logic sock_a_prog_on,
  input wire logic sock_a_prog_float,
  input wire logic sock_b_main_on,
  input wire logic sock_b_main_float,
  input wire logic sock_b_prog_on,
  input wire logic sock_b_prog_float
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic [5:0] idle_q, idle_d;
  logic [6:0] low_q, low_d;
  logic [3:0] flt_q, flt_d;
  logic scl_q;
  always_comb begin
    idle_d = (smb_clk_pin != scl_q) ? 6'h00 : idle_q + {5'h00, idle_q != 6'h3f};
    low_d = smb_data_oe_n ? 7'h00 : low_q + 7'h01;
    flt_d = flt_q - {3'h0, flt_q != 4'h0};
    if (severe_fault_det | sock_a_main_oc_det | sock_a_prog_oc_det | sock_b_main_oc_det | sock_b_prog_oc_det) begin
      flt_d = 4'hf;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= 6'h00;
      low_q <= 7'h00;
      flt_q <= 4'h0;
      scl_q <= 1'b1;
    end else begin
      idle_q <= idle_d;
      low_q <= low_d;
      flt_q <= flt_d;
      scl_q <= smb_clk_pin;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  pins_low_a: assert property (!smb_data_out && !irq_out)
    else $error("open-drain output driven high");
  main_float_a: assert property ((sock_a_main_float |-> !sock_a_main_on) and (sock_b_main_float |-> !sock_b_main_on))
    else $error("main float did not override on");
  prog_float_a: assert property ((sock_a_prog_float |-> !sock_a_prog_on) and (sock_b_prog_float |-> !sock_b_prog_on))
    else $error("prog float did not override on");
  reset_clear_a: assert property ($rose(rst_n) |-> irq_oe_n && smb_data_oe_n && !sock_a_main_on && !sock_b_prog_on)
    else $error("outputs not cleared by reset");
  irq_release_a: assert property ($rose(irq_oe_n) |-> idle_q < 6'd40)
    else $error("interrupt released without bus traffic");
  irq_cause_a: assert property ($fell(irq_oe_n) |-> flt_q != 4'h0)
    else $error("interrupt without a fault");
  ack_hold_a: assert property ($fell(smb_data_oe_n) |=> !smb_data_oe_n [*6])
    else $error("data drive shorter than a bus bit");
  drive_bound_a: assert property (low_q < 7'd100)
    else $error("data line held low too long");
endmodule
bind spsms_slave spsms_asserts chk (.core_clk, .rst_n, .smb_clk_pin, .smb_data_out, .smb_data_oe_n,
  .severe_fault_det, .sock_a_main_oc_det, .sock_a_prog_oc_det, .sock_b_main_oc_det, .sock_b_prog_oc_det,
  .irq_out, .irq_oe_n, .sock_a_main_on, .sock_a_main_float, .sock_a_prog_on, .sock_a_prog_float,
  .sock_b_main_on, .sock_b_main_float, .sock_b_prog_on, .sock_b_prog_float);

// *** tb/spsms_host.sv ***
// smbus host model: start, stop and byte transfers, 400 ns bit period
// assumes the bench resolves the open-drain data wire and feeds it back on sda
`timescale 1ns/1ps
module spsms_host (
  // bus
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // clock stands high between frames; released data floats to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bitx(input logic b, output logic r);
    // long low phase: the slave's own data needs about five core clocks through its filter
    #100 sda_low = ~b;
    #180 scl = 1'b1;
    #110 r = sda;
    #10 scl = 1'b0;
  endtask
  task automatic start();
    #200 sda_low = 1'b0;
    #120 scl = 1'b1;
    #140 sda_low = 1'b1;
    #140 scl = 1'b0;
  endtask
  task automatic stop();
    #200 sda_low = 1'b1;
    #120 scl = 1'b1;
    #140 sda_low = 1'b0;
    #140;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(ack_in, ack_out);
  endtask
endmodule

// *** tb/test_spsms_slave.sv ***
// bench for the socket power smbus slave: writes, latches, faults, interrupt pointer
// assumes the host model drives the bus and the checker is bound to the slave
`timescale 1ns/1ps
module test_spsms_slave
  import spsms_pkg::*;
;
  logic core_clk, rst_n, addr_sel, susp, irq_oe_n, oe_n, k, k2;
  logic [4:0] flt;
  logic [5:0] sa, sb;
  logic [7:0] d;
  wire scl, sda_low;
  wire sda = ~(sda_low | ~oe_n);
  int num_errors, check_count;
  spsms_host host (.scl, .sda_low, .sda);
  spsms_slave dut (.core_clk, .rst_n, .smb_clk_pin(scl), .smb_data_in(sda), .smb_data_out(), .smb_data_oe_n(oe_n),
    .addr_sel_pin(addr_sel), .suspend_select_pin(susp), .severe_fault_det(flt[4]), .sock_a_main_oc_det(flt[3]),
    .sock_a_prog_oc_det(flt[2]), .sock_b_main_oc_det(flt[1]), .sock_b_prog_oc_det(flt[0]), .irq_out(), .irq_oe_n,
    .sock_a_main_on(sa[5]), .sock_a_level_sel(sa[4]), .sock_a_main_float(sa[3]), .sock_a_prog_on(sa[2]),
    .sock_a_prog_high(sa[1]), .sock_a_prog_float(sa[0]), .sock_b_main_on(sb[5]), .sock_b_level_sel(sb[4]),
    .sock_b_main_float(sb[3]), .sock_b_prog_on(sb[2]), .sock_b_prog_high(sb[1]), .sock_b_prog_float(sb[0]));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] outs(input logic [7:0] c);
    return {c[6] & ~c[4], c[5], c[4], c[3] & ~c[1], c[2], c[1]};
  endfunction
  function automatic logic [7:0] st(input logic [4:0] f);
    return {f, VARIANT_DUAL, STATUS_RSVD};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] c);
    host.start();
    host.xfer(a, 1'b1, d, k);
    host.xfer(c, 1'b1, d, k2);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] tx);
    host.start();
    host.xfer(a, 1'b1, d, k);
    if (!k) host.xfer(tx, 1'b1, d, k2);
    host.stop();
  endtask
  task automatic fault(input logic [4:0] f);
    flt = f;
    cyc(20);
    flt = 5'h00;
    cyc(10);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_write();
    check(16'({sa, sb}), 16'h0000, "reset outputs");
    check(16'({irq_oe_n, oe_n}), 16'h0003, "reset release");
    for (int s = 0; s < 2; s++) begin
      addr_sel = s[0];
      cyc(4);
      wr({5'h14, s[0], 2'h0}, s[0] ? 8'hbc : 8'hea);
      check(16'({k, k2}), 16'h0000, "a acks");
      wr({5'h14, s[0], 2'h2}, s[0] ? 8'hc6 : 8'hd4);
      check(16'({k, k2}), 16'h0000, "b acks");
      wr({5'h14, ~s[0], 2'h0}, 8'h80);
      check(16'(k), 16'h0001, "other strap");
      check(16'({sa, sb}), 16'({outs(s[0] ? 8'hbc : 8'hea), outs(s[0] ? 8'hc6 : 8'hd4)}), "outs");
    end
    addr_sel = 1'b0;
    $display("test write done");
  endtask
  task automatic t_suspend();
    wr(8'ha0, 8'h45);
    check(16'(sa), 16'(outs(8'hbc)), "normal kept");
    susp = 1'b0;
    cyc(10);
    check(16'({sa, sb}), 16'({outs(8'h45), 6'h00}), "suspend applied");
    fault(5'h08);
    check(16'(irq_oe_n), 16'h0001, "masked");
    rd(8'ha1, 8'hff);
    check(16'({k, d}), 16'({1'b0, st(5'h08)}), "masked status");
    susp = 1'b1;
    cyc(10);
    check(16'({sa, irq_oe_n}), 16'({outs(8'hbc), 1'b1}), "normal back");
    $display("test suspend done");
  endtask
  task automatic t_refuse();
    // normal byte for channel a held last, so a wrongly executed partial to b would show
    wr(8'ha0, 8'hbc);
    wr(8'h18, 8'hc0);
    check(16'({k, k2}), 16'h0003, "pointer write");
    wr(8'ha8, 8'hc0);
    check(16'({k, k2}), 16'h0003, "bad address");
    host.start();
    host.xfer(8'ha2, 1'b1, d, k);
    for (int i = 0; i < 4; i++) host.bitx(1'b1, k2);
    host.stop();
    check(16'({sa, sb}), 16'({outs(8'hbc), outs(8'hc6)}), "partial byte");
    $display("test refuse done");
  endtask
  task automatic t_fault();
    fault(5'h08);
    fault(5'h02);
    check(16'(irq_oe_n), 16'h0000, "irq latched");
    rd(8'ha1, 8'hff);
    check(16'({k, d}), 16'({1'b0, st(5'h08)}), "status");
    check(16'(irq_oe_n), 16'h0001, "irq cleared");
    rd(8'ha1, 8'hff);
    check(16'(d), 16'(st(5'h00)), "latches cleared");
    fault(5'h01);
    rd(8'h19, 8'hff);
    check(16'({k, d, irq_oe_n}), 16'({1'b0, 5'h14, 1'b0, 2'h0, 1'b1}), "pointer reply");
    rd(8'h19, 8'hff);
    check(16'(k), 16'h0001, "nothing pending");
    rd(8'ha1, 8'hff);
    check(16'(d), 16'(st(5'h01)), "latches kept");
    $display("test fault done");
  endtask
  task automatic t_arbit();
    flt = 5'h10;
    cyc(20);
    rd(8'h19, 8'h80);
    check(16'({k, d, irq_oe_n}), 16'h0100, "rival wins");
    rd(8'ha1, 8'hff);
    cyc(10);
    check(16'({d, irq_oe_n}), 16'({st(5'h10), 1'b0}), "relatched");
    flt = 5'h00;
    cyc(10);
    rd(8'ha1, 8'hff);
    check(16'({d, irq_oe_n}), 16'({st(5'h10), 1'b1}), "fault gone");
    host.start();
    host.xfer(8'ha0, 1'b1, d, k);
    host.xfer(8'h80, 1'b1, d, k2);
    host.start();
    host.xfer(8'ha1, 1'b1, d, k);
    host.xfer(8'hff, 1'b1, d, k2);
    host.stop();
    check(16'({k, d, sa}), 16'({1'b0, st(5'h00), 6'h00}), "turnaround");
    $display("test arbitration done");
  endtask
  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    num_errors = 0;
    check_count = 0;
    rst_n = 1'b0;
    addr_sel = 1'b0;
    susp = 1'b1;
    flt = 5'h00;
    cyc(6);
    rst_n = 1'b1;
    cyc(6);
    t_write();
    t_suspend();
    t_refuse();
    t_fault();
    t_arbit();
    results();
  end
  // run needs about 190 us; cut a hang well beyond that
  initial begin
    #1000000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
endmodule
